/* File: hdl/forced_media_dma_write_cmd.sv */
/*
 Forced-media extended DMA write command engine with AXI4-Lite taskfile,
 slave-DMA word intake, one-sector buffer and media write port.
 Assumes the host DMA and the media back end share aclk; the media side
 answers every sector with one result pulse and every flush with a done.
*/
`timescale 1ns/100ps
`include "fua_write_cfg.svh"
module forced_media_dma_write_cmd
   import fua_write_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Slave-DMA word intake
   output logic             dma_request,
   input  wire logic        dma_ack,
   input  wire logic [15:0] dma_word,
   input  wire logic        dma_crc_error,
   // Media write port
   output logic             media_valid,
   input  wire logic        media_ready,
   output logic [15:0]      media_data,
   output logic             media_last,
   output logic [47:0]      media_lba,
   input  wire logic        media_result_valid,
   input  wire logic        media_unrecoverable,
   input  wire logic        media_id_not_found,
   output logic             media_flush,
   input  wire logic        media_flush_done,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   cmd_state_type state_reg;
   logic [15:0]  count_cur_prev_reg;
   logic [15:0]  lba_lo_reg, lba_mid_reg, lba_hi_reg;
   logic [7:0]   control_reg;
   logic [7:0]   err_reg;
   logic         done_seen_reg;
   logic [1:0]   irq_mask_reg;
   logic [1:0]   irq_flags;
   logic [16:0]  sectors_left_reg;
   logic [47:0]  lba_reg;
   logic [7:0]   wr_idx_reg;
   logic [7:0]   rd_idx_reg;
   logic [15:0]  sector_buf [0:255];
   logic [15:0]  media_data_reg;
   logic         media_valid_reg;
   logic         aw_held_reg, w_held_reg;
   logic [7:0]   aw_addr_reg;
   logic [31:0]  w_data_reg;
   logic [3:0]   w_strb_reg;
   logic         bvalid_reg, rvalid_reg;
   logic [1:0]   bresp_reg, rresp_reg;
   logic [31:0]  rdata_reg;
   logic         wr_fire, wr_mapped, high_order_byte_select;
   logic         start_cmd, bad_cmd, finish_ok, finish_fail;
   logic         word_take, media_take;
   logic [7:0]   cond_flags, wbyte;
   logic [31:0]  rd_value;
   logic         rd_mapped;

   assign high_order_byte_select   = control_reg[`CTL_HOB_BIT];
   assign wbyte = w_data_reg[7:0];

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side: address and data taken in either order
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   always_comb begin
      unique case (aw_addr_reg)
         `OFS_COMMAND, `OFS_SECT_COUNT, `OFS_SECT_NUMBER, `OFS_CYL_LOW,
         `OFS_CYL_HIGH, `OFS_DEV_CONTROL, `OFS_COND_FLAGS,
         `OFS_ERR_FLAGS, `OFS_IRQ_STATUS, `OFS_IRQ_MASK:
            wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Taskfile: a byte write pushes the old current byte into previous.
   // Count, address and command writes are ignored while busy, as the host may not steer a live command.
   logic tf_write;
   assign tf_write = wr_fire && w_strb_reg[0] && state_reg == st_idle;
   assign start_cmd = tf_write && aw_addr_reg == `OFS_COMMAND
                      && wbyte == `CMD_FUA_WRITE;
   assign bad_cmd   = tf_write && aw_addr_reg == `OFS_COMMAND
                      && wbyte != `CMD_FUA_WRITE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_cur_prev_reg <= 16'h0000;
         lba_lo_reg         <= 16'h0000;
         lba_mid_reg        <= 16'h0000;
         lba_hi_reg         <= 16'h0000;
      end else if (ce) begin
         if (tf_write) begin
            unique case (aw_addr_reg)
               `OFS_SECT_COUNT:
                  count_cur_prev_reg <= {count_cur_prev_reg[7:0], wbyte};
               `OFS_SECT_NUMBER:
                  lba_lo_reg  <= {lba_lo_reg[7:0], wbyte};
               `OFS_CYL_LOW:
                  lba_mid_reg <= {lba_mid_reg[7:0], wbyte};
               `OFS_CYL_HIGH:
                  lba_hi_reg  <= {lba_hi_reg[7:0], wbyte};
               default: ;
            endcase
         end
         if (finish_fail) begin
            // Failing sector address, split as the host reads it back
            lba_lo_reg  <= {lba_reg[31:24], lba_reg[7:0]};
            lba_mid_reg <= {lba_reg[39:32], lba_reg[15:8]};
            lba_hi_reg  <= {lba_reg[47:40], lba_reg[23:16]};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg  <= 8'h00;
         irq_mask_reg <= 2'b00;
      end else if (ce && wr_fire && w_strb_reg[0]) begin
         if (aw_addr_reg == `OFS_DEV_CONTROL) begin
            control_reg <= wbyte;
         end
         if (aw_addr_reg == `OFS_IRQ_MASK) begin
            irq_mask_reg <= wbyte[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer
   assign word_take  = state_reg == st_receive && dma_ack;
   assign media_take = media_valid_reg && media_ready;
   assign finish_fail = (word_take && dma_crc_error)
                      || (state_reg == st_result && media_result_valid
                          && (media_unrecoverable || media_id_not_found));
   // Ending status only after media confirms the flush
   assign finish_ok  = state_reg == st_flush && media_flush_done;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg        <= st_idle;
         sectors_left_reg <= 17'h00000;
         lba_reg          <= 48'h000000000000;
         wr_idx_reg       <= 8'h00;
      end else if (ce) begin
         unique case (state_reg)
            st_idle: begin
               if (start_cmd) begin
                  state_reg <= st_receive;
                  wr_idx_reg <= 8'h00;
                  lba_reg <= {lba_hi_reg[15:8], lba_mid_reg[15:8],
                              lba_lo_reg[15:8], lba_hi_reg[7:0],
                              lba_mid_reg[7:0], lba_lo_reg[7:0]};
                  sectors_left_reg <= (count_cur_prev_reg == 16'h0000)
                     ? `ZERO_COUNT_SECT
                     : {1'b0, count_cur_prev_reg};
               end
            end
            st_receive: begin
               if (word_take) begin
                  if (dma_crc_error) begin
                     state_reg <= st_idle;
                  end else begin
                     wr_idx_reg <= wr_idx_reg + 8'h01;
                     if (wr_idx_reg == `LAST_WORD_IDX) begin
                        state_reg <= st_commit;
                     end
                  end
               end
            end
            st_commit: begin
               if (media_take && media_last) begin
                  state_reg <= st_result;
               end
            end
            st_result: begin
               if (media_result_valid) begin
                  if (media_unrecoverable || media_id_not_found) begin
                     state_reg <= st_idle;
                  end else if (sectors_left_reg == 17'h00001) begin
                     state_reg <= st_flush;
                  end else begin
                     state_reg <= st_receive;
                     sectors_left_reg <= sectors_left_reg - 17'h00001;
                     lba_reg <= lba_reg + 48'h000000000001;
                  end
               end
            end
            st_flush: begin
               if (media_flush_done) begin
                  state_reg <= st_idle;
               end
            end
         endcase
      end
   end

   // One-sector staging buffer
   always_ff @(posedge aclk) begin
      if (ce && word_take) begin
         sector_buf[wr_idx_reg] <= dma_word;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         media_valid_reg <= 1'b0;
         media_data_reg  <= 16'h0000;
         rd_idx_reg      <= 8'h00;
      end else if (ce) begin
         if (state_reg == st_receive && word_take && !dma_crc_error
             && wr_idx_reg == `LAST_WORD_IDX) begin
            media_valid_reg <= 1'b1;
            media_data_reg  <= (wr_idx_reg == 8'h00) ? dma_word
                                                      : sector_buf[0];
            rd_idx_reg      <= 8'h00;
         end else if (media_take) begin
            if (rd_idx_reg == `LAST_WORD_IDX) begin
               media_valid_reg <= 1'b0;
            end else begin
               media_data_reg <= sector_buf[rd_idx_reg + 8'h01];
               rd_idx_reg     <= rd_idx_reg + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error and completion status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_reg       <= 8'h00;
         done_seen_reg <= 1'b0;
      end else if (ce) begin
         if (start_cmd) begin
            err_reg       <= 8'h00;
            done_seen_reg <= 1'b0;
         end else if (bad_cmd) begin
            err_reg       <= 8'h00;
            err_reg[`ER_ABORT] <= 1'b1;
            done_seen_reg <= 1'b1;
         end else if (finish_fail) begin
            done_seen_reg <= 1'b1;
            err_reg[`ER_ABORT] <= 1'b1;
            err_reg[`ER_CRC]   <= word_take && dma_crc_error;
            err_reg[`ER_IDNF]  <= state_reg == st_result
                                  && media_id_not_found;
         end else if (finish_ok) begin
            done_seen_reg <= 1'b1;
         end
      end
   end

   always_comb begin
      cond_flags              = 8'h00;
      cond_flags[`ST_BUSY]    = state_reg != st_idle;
      cond_flags[`ST_READY]   = 1'b1;
      cond_flags[`ST_FAULT]   = 1'b0;
      cond_flags[`ST_SEEK]    = done_seen_reg;
      cond_flags[`ST_DRQ]     = state_reg == st_receive;
      cond_flags[`ST_CORR]    = 1'b0;
      cond_flags[`ST_INDEX]   = 1'b0;
      cond_flags[`ST_ERR]     = |err_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt: one completion event per command
   logic irq_clear_done, irq_clear_fail, any_finish;
   assign any_finish = finish_ok || finish_fail || bad_cmd;
   assign irq_clear_done = wr_fire && w_strb_reg[0]
      && aw_addr_reg == `OFS_IRQ_STATUS && wbyte[`IRQ_DONE_BIT];
   assign irq_clear_fail = wr_fire && w_strb_reg[0]
      && aw_addr_reg == `OFS_IRQ_STATUS && wbyte[`IRQ_FAIL_BIT];

   sticky_event_flag done_flag (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .set_pulse   (any_finish),
      .clear_pulse (irq_clear_done),
      .flag        (irq_flags[`IRQ_DONE_BIT])
   );

   sticky_event_flag fail_flag (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .set_pulse   (finish_fail || bad_cmd),
      .clear_pulse (irq_clear_fail),
      .flag        (irq_flags[`IRQ_FAIL_BIT])
   );

   assign irq = |(irq_flags & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side, one cycle to answer
   always_comb begin
      rd_value  = 32'h00000000;
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         `OFS_COMMAND:     rd_value[7:0] = cond_flags;
         `OFS_SECT_COUNT:  rd_value[7:0] = high_order_byte_select ? count_cur_prev_reg[15:8]
                                               : count_cur_prev_reg[7:0];
         `OFS_SECT_NUMBER: rd_value[7:0] = high_order_byte_select ? lba_lo_reg[15:8]
                                               : lba_lo_reg[7:0];
         `OFS_CYL_LOW:     rd_value[7:0] = high_order_byte_select ? lba_mid_reg[15:8]
                                               : lba_mid_reg[7:0];
         `OFS_CYL_HIGH:    rd_value[7:0] = high_order_byte_select ? lba_hi_reg[15:8]
                                               : lba_hi_reg[7:0];
         `OFS_DEV_CONTROL: rd_value[7:0] = control_reg;
         `OFS_COND_FLAGS:  rd_value[7:0] = cond_flags;
         `OFS_ERR_FLAGS:   rd_value[7:0] = err_reg;
         `OFS_IRQ_STATUS:  rd_value[1:0] = irq_flags;
         `OFS_IRQ_MASK:    rd_value[1:0] = irq_mask_reg;
         default:          rd_mapped = 1'b0;
      endcase
   end

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign dma_request = state_reg == st_receive;
   assign media_valid = media_valid_reg;
   assign media_data  = media_data_reg;
   assign media_last  = rd_idx_reg == `LAST_WORD_IDX;
   assign media_lba   = lba_reg;
   assign media_flush = state_reg == st_flush;
endmodule

/* File: hdl/fua_write_cfg.svh */
/*
 Register map, field positions and fixed figures of the forced-media
 extended DMA write command block. Assumes inclusion by bare name.
*/
// Functional notes
// - Command code 3Dh written to command register starts this write.
// - Accept one or more sectors from the host, then commit them to media.
// - All data reaches media before ending status, even with write cache on.
// - Sector data moves as 16-bit words, one word per transfer.
// - Each word moves only under device DMA request, serviced by host DMA.
// - Exactly one interrupt per command, after transfer ends and status ready.
// - Unrecoverable error stops the write at the failing sector.
// - Sector count current byte is bits 7:0, previous byte bits 15:8.
// - Sector count of zero means 65,536 sectors.
// - Sector number holds address 7:0 current, 31:24 previous.
// - Cylinder low holds address 15:8 current, 39:32 previous.
// - Cylinder high holds address 23:16 current, 47:40 previous.
// - After unrecoverable error address registers hold failing sector address.
`ifndef FUA_WRITE_CFG_SVH
`define FUA_WRITE_CFG_SVH

`define OFS_COMMAND      8'h00
`define OFS_SECT_COUNT   8'h04
`define OFS_SECT_NUMBER  8'h08
`define OFS_CYL_LOW      8'h0c
`define OFS_CYL_HIGH     8'h10
`define OFS_DEV_CONTROL  8'h14
`define OFS_COND_FLAGS   8'h18
`define OFS_ERR_FLAGS    8'h1c
`define OFS_IRQ_STATUS   8'h20
`define OFS_IRQ_MASK     8'h24

`define CMD_FUA_WRITE    8'h3d

`define CTL_HOB_BIT      7
`define CTL_WCACHE_BIT   0

`define ST_BUSY          7
`define ST_READY         6
`define ST_FAULT         5
`define ST_SEEK          4
`define ST_DRQ           3
`define ST_CORR          2
`define ST_INDEX         1
`define ST_ERR           0

`define ER_CRC           7
`define ER_IDNF          4
`define ER_ABORT         2

`define IRQ_DONE_BIT     0
`define IRQ_FAIL_BIT     1

`define WORDS_PER_SECTOR 9'h100
`define LAST_WORD_IDX    8'hff
`define ZERO_COUNT_SECT  17'h10000

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

/* File: hdl/fua_write_pkg.sv */
/*
 Types shared by the forced-media write command block.
 Assumes nothing of its surroundings.
*/
package fua_write_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_receive,
      st_commit,
      st_result,
      st_flush
   } cmd_state_type;
endpackage

/* File: hdl/sticky_event_flag.sv */
/*
 One sticky event bit: set by a hardware pulse, cleared by software.
 Assumes a single clock, synchronous active-low reset and clock enable.
*/
`timescale 1ns/100ps
module sticky_event_flag (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic set_pulse,
   input  wire logic clear_pulse,
   output logic      flag
);
   logic flag_reg;

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'b0;
      end else if (ce) begin
         if (set_pulse) begin
            flag_reg <= 1'b1;
         end else if (clear_pulse) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign flag = flag_reg;
endmodule

/* File: sim/forced_media_dma_write_cmd_monitor.sv */
/*
 Port assertions for the forced-media write engine.
 Assumes one clock with a synchronous active-low reset; bound below.
*/
`timescale 1ns/100ps
module fua_write_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        dma_request,
   input wire logic        dma_ack,
   input wire logic        dma_crc_error,
   input wire logic        media_valid,
   input wire logic        media_ready,
   input wire logic        media_last,
   input wire logic [15:0] media_data,
   input wire logic [47:0] media_lba,
   input wire logic        media_result_valid,
   input wire logic        media_unrecoverable,
   input wire logic        media_flush,
   input wire logic        media_flush_done,
   input wire logic        irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_one_phase: assert property (
      !(dma_request && (media_valid || media_flush)))
      else $error("dma request during media phase");
   a_flush_quiet: assert property (media_flush |-> !media_valid)
      else $error("media word during flush");
   a_flush_end: assert property (
      media_flush && media_flush_done |=> !media_flush && !dma_request)
      else $error("flush held after done");
   a_last_stops: assert property (
      media_valid && media_ready && media_last |=> !media_valid)
      else $error("media word after last");
   a_media_hold: assert property (media_valid && !media_ready |=>
      media_valid && $stable(media_data) && $stable(media_lba))
      else $error("media word changed while stalled");
   a_fail_stop: assert property (media_result_valid &&
      media_unrecoverable |=> (!dma_request && !media_flush)[*2])
      else $error("work continued past failing sector");
   a_crc_stop: assert property (
      dma_request && dma_ack && dma_crc_error |=> !dma_request[*2])
      else $error("intake continued after bad word");
   a_irq_at_end: assert property (
      $rose(irq) |-> !dma_request && !media_valid && !media_flush)
      else $error("interrupt before transfer ended");
   cover property ($rose(irq));
   cover property (media_flush && media_flush_done);
   cover property (dma_request && dma_ack && dma_crc_error);
endmodule

bind forced_media_dma_write_cmd fua_write_monitor fua_write_monitor_inst (.*);

/* File: sim/fua_host_media_model.sv */
/*
 Host slave-DMA channel and media back end facing the write engine.
 Assumes clr is pulsed by the bench before each command.
*/
`timescale 1ns/100ps
module fua_host_media_model (
   input  wire logic        aclk,
   input  wire logic        clr,
   input  wire logic        slow,
   input  wire logic [1:0]  fail_kind,
   input  wire logic [16:0] fail_at,
   input  wire logic [47:0] base,
   input  wire logic        dma_request,
   output logic             dma_ack,
   output logic [15:0]      dma_word,
   output logic             dma_crc_error,
   input  wire logic        media_valid,
   output logic             media_ready,
   input  wire logic [15:0] media_data,
   input  wire logic        media_last,
   input  wire logic [47:0] media_lba,
   output logic             media_result_valid,
   output logic             media_unrecoverable,
   output logic             media_id_not_found,
   input  wire logic        media_flush,
   output logic             media_flush_done,
   output int               sect,
   output int               derr
);
   logic [7:0] n = 8'h00;
   logic       pend = 1'b0;
   int         wcnt = 0;
   int         mcnt = 0;
   // Idle data line shows the inverse so a stale word cannot pass
   assign dma_word = dma_ack ? wcnt[15:0] : ~wcnt[15:0];
   assign dma_crc_error = dma_ack && fail_kind == 2'h3 && wcnt == fail_at;
   always @(posedge aclk) begin
      n <= n + 8'h01;
      dma_ack <= dma_request && (!slow || n[0]);
      media_ready <= !slow || n[1];
      pend <= media_valid && media_ready && media_last;
      media_result_valid <= pend;
      media_unrecoverable <= pend && fail_kind == 2'h1 && sect == fail_at;
      media_id_not_found <= pend && fail_kind == 2'h2 && sect == fail_at;
      media_flush_done <= media_flush && !media_flush_done;
      if (pend) sect <= sect + 1;
      if (dma_request && dma_ack) wcnt <= wcnt + 1;
      if (media_valid && media_ready) begin
         mcnt <= mcnt + 1;
         if (media_data !== mcnt[15:0] || media_lba !== base + 48'(sect))
            derr <= derr + 1;
      end
      if (clr) begin
         {wcnt, mcnt, sect, derr} <= '0;
      end
   end
endmodule

/* File: sim/forced_media_dma_write_cmd_bench.sv */
/*
 Register-level bench for the forced-media write engine.
 Assumes the host/media model and the bound port monitor.
*/
`timescale 1ns/100ps
`include "fua_write_cfg.svh"
module forced_media_dma_write_cmd_bench
   import fua_write_pkg::*;
;
   localparam logic [47:0] BASE = 48'h665544332211;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, clr = 1'b0, slow = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ee;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, dma_request, dma_ack, dma_crc_error, media_valid;
   logic media_ready, media_last, media_result_valid, media_unrecoverable;
   logic media_id_not_found, media_flush, media_flush_done, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, fail_kind = 2'h0;
   logic [15:0] dma_word, media_data;
   logic [47:0] media_lba, fl;
   logic [16:0] fail_at = 17'h0;
   int sect, derr, n_mismatch = 0, compares = 0;
   forced_media_dma_write_cmd forced_media_dma_write_cmd_inst (.*);
   fua_host_media_model fua_host_media_model_inst (.*, .base(BASE));
   always #50 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge aclk);
      {aw, w} = 2'h3;
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end while (aw || w);
      while (!s_axi_bvalid) @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      {rv, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   // Address bytes go high half first so the shift lands them right
   task automatic go(input logic [15:0] cnt, input logic [7:0] code);
      int t;
      clr <= 1'b1;
      wr(`OFS_IRQ_STATUS, 32'h3);
      clr <= 1'b0;
      wr(`OFS_SECT_COUNT, {24'h0, cnt[15:8]});
      wr(`OFS_SECT_COUNT, {24'h0, cnt[7:0]});
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_SECT_NUMBER + 8'(4 * i), {24'h0, BASE[24 + 8 * i +: 8]});
         wr(`OFS_SECT_NUMBER + 8'(4 * i), {24'h0, BASE[8 * i +: 8]});
      end
      wr(`OFS_COMMAND, {24'h0, code});
      t = 0;
      while (!irq && t < 20000) begin
         @(posedge aclk);
         t++;
      end
      chk(irq, 1);
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(100 * 60000);
      n_mismatch++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`OFS_IRQ_MASK, 32'h3);
      go(16'h0002, `CMD_FUA_WRITE);
      chk(sect, 2);
      chk(derr, 0);
      rd(`OFS_COND_FLAGS);
      chk(rv, 32'h50);
      rd(`OFS_ERR_FLAGS);
      chk(rv, 32'h0);
      rd(`OFS_IRQ_STATUS);
      chk(rv, 32'h1);
      go(16'h0001, 8'h35);
      rd(`OFS_ERR_FLAGS);
      chk(rv, 32'h04);
      rd(`OFS_COMMAND);
      chk(rv, 32'h51);
      wr(`OFS_IRQ_MASK, 32'h0);
      chk(irq, 0);
      wr(`OFS_IRQ_MASK, 32'h3);
      wr(8'h40, 32'h0);
      chk(rsp, `RESP_SLVERR);
      rd(8'h40);
      chk(rsp, `RESP_SLVERR);
      // Stalling far side so the engine sees both slow paths
      for (int k = 1; k < 4; k++) begin
         slow <= 1'b1;
         fail_kind <= 2'(k);
         fail_at <= (k == 3) ? 17'h12c : {16'h0, k == 1};
         ee = (k == 1) ? 8'h04 : (k == 2) ? 8'h14 : 8'h84;
         fl = BASE + 48'(k != 2);
         go((k == 1) ? 16'h0000 : 16'h0003, `CMD_FUA_WRITE);
         rd(`OFS_ERR_FLAGS);
         chk(rv, {24'h0, ee});
         chk(sect, (k == 1) ? 2 : 1);
         for (int h = 0; h < 2; h++) begin
            wr(`OFS_DEV_CONTROL, h ? 32'h80 : 32'h0);
            for (int i = 0; i < 3; i++) begin
               rd(`OFS_SECT_NUMBER + 8'(4 * i));
               chk(rv, {24'h0, fl[8 * (i + 3 * h) +: 8]});
            end
         end
         wr(`OFS_DEV_CONTROL, 32'h0);
      end
      test_done;
   end
endmodule
